/* verilog/option_bytes_regs.svh */
`ifndef OPTION_BYTES_REGS_SVH
`define OPTION_BYTES_REGS_SVH
// option byte indices inside the nonvolatile option store
`define OPT_IDX_BOOT 2'h0
`define OPT_IDX_LOADER 2'h1
`define OPT_IDX_BROWNOUT 2'h2
`define OPT_IDX_WATCHDOG 2'h3
// boot/security byte fields
`define OPT_BOOT_SEL_BIT 7
`define OPT_PWM_TRI_BIT 5
`define OPT_DBG_DIS_BIT 4
`define OPT_RST_PIN_BIT 2
`define OPT_UNLOCK_BIT 1
// loader byte field
`define OPT_LOADER_SIZE_MSB 2
// brownout byte fields
`define OPT_BOD_ON_BIT 7
`define OPT_BOD_LVL_MSB 5
`define OPT_BOD_LVL_LSB 4
`define OPT_BOD_INHIBIT_BIT 3
`define OPT_BOD_RST_BIT 2
// watchdog byte field
`define OPT_WDT_MSB 7
`define OPT_WDT_LSB 4
`define OPT_WDT_TIMER_ONLY 4'hF
`define OPT_WDT_STOP_IDLE 4'h5
// erased option byte value
`define OPT_ERASED 8'hFF
// flash size in kilobytes, blank read value and reload step count
`define FLASH_TOTAL_KB 5'h10
`define FLASH_BLANK_READ 8'hFF
`define LOAD_CYCLES 3'h4
`endif

/* verilog/option_bytes_pkg.sv */
package option_bytes_pkg;
    // decoded options handed to consumers
    typedef struct packed {
        logic boot_from_app;
        logic pwm_tri_on_halt;
        logic debugger_on;
        logic reset_pin_is_reset;
        logic chip_locked;
        logic [4:0] loader_kb;
        logic [4:0] app_kb;
        logic bod_on;
        logic [1:0] bod_level;
        logic bod_inhibit;
        logic bod_reset_on;
        logic wdt_reset_on;
        logic wdt_stop_idle;
    } options_t;
    // programmer access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic chip_erase;
        logic is_option;
        logic [1:0] opt_idx;
        logic [12:0] addr;
        logic [7:0] wdata;
    } prog_req_t;
    typedef enum logic [2:0] {
        ST_LOAD = 3'b001,
        ST_RUN = 3'b010,
        ST_ERASE = 3'b100
    } load_state_t;
endpackage

/* verilog/option_store.sv */
`include "option_bytes_regs.svh"
// four-byte nonvolatile option store model with registered read
module option_store (
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic [1:0] RD_IDX_IN,
    input wire logic WR_IN,
    input wire logic [1:0] WR_IDX_IN,
    input wire logic [7:0] WR_DATA_IN,
    input wire logic ERASE_ALL_IN,
    output logic [7:0] RD_DATA_OUT
);
    import option_bytes_pkg::*;
    // whole store plus read register as one state word
    typedef struct packed {
        logic [3:0][7:0] mem;
        logic [7:0] rdata;
    } store_t;
    store_t q;
    store_t next_q;

    // program clears bits only, erase returns bytes to ones
    always_comb
    begin
        next_q = q;
        next_q.rdata = q.mem[RD_IDX_IN];
        if (ERASE_ALL_IN)
        begin
            next_q.mem = {4{`OPT_ERASED}};
        end
        else if (WR_IN)
        begin
            next_q.mem[WR_IDX_IN] = q.mem[WR_IDX_IN] & WR_DATA_IN;
        end
    end

    // reset stands for a blank part; real contents persist in silicon
    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            q <= {{4{`OPT_ERASED}}, `OPT_ERASED};
        end
        else
        begin
            q <= next_q;
        end
    end

    assign RD_DATA_OUT = q.rdata;
endmodule

/* verilog/option_byte_decoder.sv */
`include "option_bytes_regs.svh"
module option_byte_decoder (
    // clock and reset causes
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic POR_IN,
    input wire logic ANY_RESET_IN,
    input wire logic SW_RESET_IN,
    // programmer side
    input wire option_bytes_pkg::prog_req_t PROG_REQ_IN,
    input wire logic [7:0] FLASH_RDATA_IN,
    // software, debug and supply inputs
    input wire logic SW_FLASH_WR_IN,
    input wire logic DEBUG_MODE_IN,
    input wire logic DEBUG_HALT_IN,
    input wire logic [5:0] PWM_PIN_SELECT_IN,
    input wire logic HARD_FAULT_IN,
    input wire logic VDD_LOW_IN,
    input wire logic IDLE_IN,
    input wire logic SW_CTRL_WR_IN,
    input wire logic [1:0] SW_CTRL_DATA_IN,
    // decoded options and run state
    output option_bytes_pkg::options_t OPTIONS_OUT,
    output logic READY_OUT,
    output logic BOOT_FROM_APP_OUT,
    // effects on pins and on the reset logic
    output logic [5:0] PWM_TRISTATE_OUT,
    output logic HARD_FAULT_RESET_OUT,
    output logic HARD_FAULT_FLAG_OUT,
    output logic PIN_RESET_ENABLE_OUT,
    // programmer answers and flash strobes
    output logic [7:0] PROG_RDATA_OUT,
    output logic PROG_RVALID_OUT,
    output logic FLASH_TOOL_WR_OUT,
    output logic FLASH_ERASE_ALL_OUT,
    // software flash gate, brownout and watchdog
    output logic SW_FLASH_WR_OK_OUT,
    output logic BROWNOUT_RESET_OUT,
    output logic WDT_RUNNING_OUT,
    output logic [1:0] SW_CTRL_OUT
);
    import option_bytes_pkg::*;

    // whole module state in one word
    typedef struct packed {
        // reload walk, run or erase
        load_state_t st;
        // reload step counter
        logic [2:0] cnt;
        // option byte being fetched
        logic [1:0] idx;
        // working copies of the four option bytes
        logic [3:0][7:0] shadow;
        // decoded view of the working copies
        options_t opt;
        // last tool read answer
        logic [7:0] prd;
        // tool read answer valid
        logic prv;
        // sticky debug hard fault flag
        logic fault_flag;
        // software-owned control copies
        logic [1:0] sw_ctrl;
        // boot block chosen at the last non-software reset
        logic boot_app;
    } state_t;
    state_t q;
    state_t next_q;

    // glue between the walk and the store
    logic [7:0] store_rdata; // registered store output
    logic store_wr; // tool programs an option byte
    logic store_erase; // whole chip erase reaches store

    // erased or reserved bits never change decoding
    function automatic options_t decode(input logic [3:0][7:0] b);
        options_t o;
        logic [2:0] ld;
        logic [3:0] wd;
        o = '0;
        // reserved bits of the loader and watchdog bytes are never looked at
        ld = b[`OPT_IDX_LOADER][`OPT_LOADER_SIZE_MSB:0];
        wd = b[`OPT_IDX_WATCHDOG][`OPT_WDT_MSB:`OPT_WDT_LSB];
        // boot and security byte
        o.boot_from_app = b[`OPT_IDX_BOOT][`OPT_BOOT_SEL_BIT];
        o.pwm_tri_on_halt = b[`OPT_IDX_BOOT][`OPT_PWM_TRI_BIT];
        o.debugger_on = !b[`OPT_IDX_BOOT][`OPT_DBG_DIS_BIT];
        o.reset_pin_is_reset = b[`OPT_IDX_BOOT][`OPT_RST_PIN_BIT];
        o.chip_locked = !b[`OPT_IDX_BOOT][`OPT_UNLOCK_BIT];
        // loader split; every 0xx code folds into the default arm
        case (ld)
            3'h7: o.loader_kb = 5'h0;
            3'h6: o.loader_kb = 5'h1;
            3'h5: o.loader_kb = 5'h2;
            3'h4: o.loader_kb = 5'h3;
            default: o.loader_kb = 5'h4;
        endcase
        // no loader block gives the whole array to the application
        o.app_kb = (ld == 3'h7) ? `FLASH_TOTAL_KB : 5'h8 - o.loader_kb;
        // brownout byte
        o.bod_on = b[`OPT_IDX_BROWNOUT][`OPT_BOD_ON_BIT];
        o.bod_level = b[`OPT_IDX_BROWNOUT][`OPT_BOD_LVL_MSB:`OPT_BOD_LVL_LSB];
        o.bod_inhibit = b[`OPT_IDX_BROWNOUT][`OPT_BOD_INHIBIT_BIT];
        o.bod_reset_on = b[`OPT_IDX_BROWNOUT][`OPT_BOD_RST_BIT];
        // watchdog code; any value but the timer-only code keeps reset on
        o.wdt_reset_on = (wd != `OPT_WDT_TIMER_ONLY);
        o.wdt_stop_idle = (wd == `OPT_WDT_STOP_IDLE);
        return o;
    endfunction

    // nonvolatile option bytes
    // read index follows the walk; writes come straight from the tool
    option_store u_store (
        .CLK_IN(CLK_IN),
        .RSTN_IN(RSTN_IN),
        .RD_IDX_IN(q.idx),
        .WR_IN(store_wr),
        .WR_IDX_IN(PROG_REQ_IN.opt_idx),
        .WR_DATA_IN(PROG_REQ_IN.wdata),
        .ERASE_ALL_IN(store_erase),
        .RD_DATA_OUT(store_rdata)
    );

    // option writes refused while locked; erase allowed while running, locked or not
    always_comb
    begin
        store_wr = (q.st == ST_RUN) && PROG_REQ_IN.wr && PROG_REQ_IN.is_option
            && !q.opt.chip_locked;
        // a whole erase is the only way out of the lock
        store_erase = (q.st == ST_RUN) && PROG_REQ_IN.chip_erase;
    end

    // reload walk, tool access and fault handling
    always_comb
    begin
        next_q = q;
        // valid is a one-cycle pulse
        next_q.prv = 1'b0;
        // hardware sets the fault flag; it stays until reset
        if (HARD_FAULT_IN && DEBUG_MODE_IN && q.opt.debugger_on)
        begin
            next_q.fault_flag = 1'b1;
        end
        // software may overwrite the copied controls at any time but the last reload step
        if (SW_CTRL_WR_IN)
        begin
            next_q.sw_ctrl = SW_CTRL_DATA_IN;
        end
        // walk, run and erase states
        case (q.st)
            ST_LOAD:
            begin
                // read data lag the index by one cycle, so step after capture
                next_q.cnt = q.cnt + 3'h1;
                if (q.cnt != 3'h0)
                begin
                    // brownout byte only refreshed on power-on
                    if ((q.idx - 2'h1) != `OPT_IDX_BROWNOUT || POR_IN)
                    begin
                        next_q.shadow[q.idx - 2'h1] = store_rdata;
                    end
                end
                // index wraps to zero after the last byte
                next_q.idx = q.idx + 2'h1;
                // last byte captured: decode and start running
                if (q.cnt == `LOAD_CYCLES)
                begin
                    next_q.st = ST_RUN;
                    next_q.opt = decode(next_q.shadow);
                    // control copies start from the fresh options
                    next_q.sw_ctrl = {next_q.opt.wdt_reset_on,
                        next_q.opt.bod_on};
                    // software reset keeps the previous boot block
                    if (!SW_RESET_IN)
                    begin
                        next_q.boot_app = next_q.opt.boot_from_app;
                    end
                end
            end
            ST_RUN:
            begin
                // erase has priority over a read or an option write
                if (PROG_REQ_IN.chip_erase)
                begin
                    next_q.st = ST_ERASE;
                end
                // reads answer one cycle later
                else if (PROG_REQ_IN.rd)
                begin
                    next_q.prv = 1'b1;
                    if (PROG_REQ_IN.is_option)
                    begin
                        // option space is never blanked by the lock
                        next_q.prd = q.shadow[PROG_REQ_IN.opt_idx];
                    end
                    else
                    begin
                        // main array shows blank ones while locked
                        next_q.prd = q.opt.chip_locked ? `FLASH_BLANK_READ
                            : FLASH_RDATA_IN;
                    end
                end
            end
            ST_ERASE:
            begin
                // erased option bytes are all ones and decode with the chip unlocked
                next_q.shadow = {4{`OPT_ERASED}};
                next_q.opt = decode({4{`OPT_ERASED}});
                // one cycle of not ready, then running again
                next_q.st = ST_RUN;
            end
            default:
            begin
                // unused state codes fall back into a reload
                next_q.st = ST_LOAD;
            end
        endcase
        if (ANY_RESET_IN)
        begin
            // any reset restarts the reload walk
            next_q.st = ST_LOAD;
            next_q.cnt = 3'h0;
            next_q.idx = 2'h0;
            // reset wins over a fault in the same cycle
            next_q.fault_flag = 1'b0;
        end
    end

    // single state register
    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            // options stay cleared until the walk has run
            q <= '{st: ST_LOAD, cnt: 3'h0, idx: 2'h0,
                shadow: {4{`OPT_ERASED}}, opt: '0, prd: 8'h00,
                prv: 1'b0, fault_flag: 1'b0, sw_ctrl: 2'h0, boot_app: 1'b0};
        end
        else
        begin
            // every field moves on each edge
            q <= next_q;
        end
    end

    // consumer outputs; pwm tristate is per channel
    always_comb
    begin
        // decoded view for the consumers
        OPTIONS_OUT = q.opt;
        // requests are taken only while running
        READY_OUT = (q.st == ST_RUN);
        BOOT_FROM_APP_OUT = q.boot_app;
        // pins float only on halt, and only where pwm owns the pin
        PWM_TRISTATE_OUT = (DEBUG_HALT_IN && q.opt.pwm_tri_on_halt)
            ? PWM_PIN_SELECT_IN : 6'h00;
        // debugging with the debugger on turns a fault into a flag
        HARD_FAULT_RESET_OUT = HARD_FAULT_IN
            && !(DEBUG_MODE_IN && q.opt.debugger_on);
        HARD_FAULT_FLAG_OUT = q.fault_flag;
        // shared pin acts as reset or as plain input
        PIN_RESET_ENABLE_OUT = q.opt.reset_pin_is_reset;
        // tool read answer
        PROG_RDATA_OUT = q.prd;
        PROG_RVALID_OUT = q.prv;
        // tool programming of the main array
        FLASH_TOOL_WR_OUT = (q.st == ST_RUN) && PROG_REQ_IN.wr
            && !PROG_REQ_IN.is_option && !q.opt.chip_locked;
        // whole erase passes on to the flash array
        FLASH_ERASE_ALL_OUT = store_erase;
        // lock plays no part in software writes
        SW_FLASH_WR_OK_OUT = SW_FLASH_WR_IN && !(q.opt.bod_on && q.opt.bod_inhibit
            && VDD_LOW_IN);
        // brownout reset needs both detection and its own enable
        BROWNOUT_RESET_OUT = q.opt.bod_on && q.opt.bod_reset_on && VDD_LOW_IN;
        // watchdog counts unless it is a plain timer or parked in idle
        WDT_RUNNING_OUT = q.opt.wdt_reset_on
            && !(IDLE_IN && q.opt.wdt_stop_idle);
        // software-visible control copies
        SW_CTRL_OUT = q.sw_ctrl;
    end
endmodule

/* bench/option_decoder_monitor.sv */
module option_decoder_monitor (
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic ANY_RESET_IN,
    input wire option_bytes_pkg::prog_req_t PROG_REQ_IN,
    input wire logic [7:0] FLASH_RDATA_IN,
    input wire logic SW_FLASH_WR_IN,
    input wire logic DEBUG_MODE_IN,
    input wire logic DEBUG_HALT_IN,
    input wire logic [5:0] PWM_PIN_SELECT_IN,
    input wire logic HARD_FAULT_IN,
    input wire logic VDD_LOW_IN,
    input wire option_bytes_pkg::options_t OPTIONS_OUT,
    input wire logic READY_OUT,
    input wire logic [5:0] PWM_TRISTATE_OUT,
    input wire logic HARD_FAULT_RESET_OUT,
    input wire logic HARD_FAULT_FLAG_OUT,
    input wire logic [7:0] PROG_RDATA_OUT,
    input wire logic PROG_RVALID_OUT,
    input wire logic FLASH_TOOL_WR_OUT,
    input wire logic FLASH_ERASE_ALL_OUT,
    input wire logic SW_FLASH_WR_OK_OUT,
    input wire logic BROWNOUT_RESET_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    import option_bytes_pkg::*;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    // a tool read taken while ready is answered on the next edge
    read_answer_a: assert property (READY_OUT && PROG_REQ_IN.rd |=> PROG_RVALID_OUT)
        else $error("read not answered");
    // a locked part shows blank flash to the tool
    locked_read_a: assert property (READY_OUT && PROG_REQ_IN.rd
        && !PROG_REQ_IN.is_option && OPTIONS_OUT.chip_locked |=> PROG_RDATA_OUT == 8'hFF)
        else $error("locked data shown");
    open_read_a: assert property (READY_OUT && PROG_REQ_IN.rd && !PROG_REQ_IN.is_option
        && !OPTIONS_OUT.chip_locked |=> PROG_RDATA_OUT == $past(FLASH_RDATA_IN))
        else $error("flash data lost");
    locked_write_a: assert property (OPTIONS_OUT.chip_locked |-> !FLASH_TOOL_WR_OUT)
        else $error("locked flash written");
    // erase costs exactly one cycle of not ready
    erase_step_a: assert property (FLASH_ERASE_ALL_OUT |=> !READY_OUT ##1 READY_OUT)
        else $error("erase timing wrong");
    // options settled: pin effects follow them at once
    pwm_float_a: assert property (READY_OUT && $stable(OPTIONS_OUT) |->
        PWM_TRISTATE_OUT == ((DEBUG_HALT_IN && OPTIONS_OUT.pwm_tri_on_halt) ? PWM_PIN_SELECT_IN
        : 6'h00)) else $error("pwm tristate wrong");
    brownout_reset_a: assert property (READY_OUT && $stable(OPTIONS_OUT) |->
        BROWNOUT_RESET_OUT == (OPTIONS_OUT.bod_on && OPTIONS_OUT.bod_reset_on && VDD_LOW_IN))
        else $error("brownout reset wrong");
    write_inhibit_a: assert property (READY_OUT && $stable(OPTIONS_OUT)
        && SW_FLASH_WR_IN |->
        SW_FLASH_WR_OK_OUT == !(OPTIONS_OUT.bod_on && OPTIONS_OUT.bod_inhibit && VDD_LOW_IN))
        else $error("software write gate wrong");
    fault_flag_a: assert property (HARD_FAULT_IN && DEBUG_MODE_IN
        && OPTIONS_OUT.debugger_on && !ANY_RESET_IN
        |-> !HARD_FAULT_RESET_OUT ##1 HARD_FAULT_FLAG_OUT)
        else $error("debug fault not flagged");
    locked_read_c: cover property (PROG_RVALID_OUT && OPTIONS_OUT.chip_locked);
    erase_c: cover property (FLASH_ERASE_ALL_OUT);
    fault_c: cover property (HARD_FAULT_IN && DEBUG_MODE_IN && OPTIONS_OUT.debugger_on);
endmodule
bind option_byte_decoder option_decoder_monitor monitor_inst (.CLK_IN(CLK_IN),
    .RSTN_IN(RSTN_IN), .ANY_RESET_IN(ANY_RESET_IN), .PROG_REQ_IN(PROG_REQ_IN),
    .FLASH_RDATA_IN(FLASH_RDATA_IN), .SW_FLASH_WR_IN(SW_FLASH_WR_IN),
    .DEBUG_MODE_IN(DEBUG_MODE_IN), .DEBUG_HALT_IN(DEBUG_HALT_IN),
    .PWM_PIN_SELECT_IN(PWM_PIN_SELECT_IN), .HARD_FAULT_IN(HARD_FAULT_IN),
    .VDD_LOW_IN(VDD_LOW_IN), .OPTIONS_OUT(OPTIONS_OUT), .READY_OUT(READY_OUT),
    .PWM_TRISTATE_OUT(PWM_TRISTATE_OUT), .HARD_FAULT_RESET_OUT(HARD_FAULT_RESET_OUT),
    .HARD_FAULT_FLAG_OUT(HARD_FAULT_FLAG_OUT), .PROG_RDATA_OUT(PROG_RDATA_OUT),
    .PROG_RVALID_OUT(PROG_RVALID_OUT), .FLASH_TOOL_WR_OUT(FLASH_TOOL_WR_OUT),
    .FLASH_ERASE_ALL_OUT(FLASH_ERASE_ALL_OUT), .SW_FLASH_WR_OK_OUT(SW_FLASH_WR_OK_OUT),
    .BROWNOUT_RESET_OUT(BROWNOUT_RESET_OUT));

/* bench/option_tool_model.sv */
module option_tool_model (
    input wire logic clk_in,
    input wire logic ready_in,
    output option_bytes_pkg::prog_req_t req_out,
    output logic [7:0] flash_rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import option_bytes_pkg::*;
    // flash array seen by the tool: a fixed scramble of the address
    assign flash_rdata_out = req_out.addr[7:0] ^ 8'h5A;
    initial req_out = '0;
    // kind is {read, write, whole erase, option space}; held over one rising edge
    task automatic issue(input logic [3:0] kind, input logic [1:0] idx,
        input logic [12:0] addr, input logic [7:0] data);
        @(negedge clk_in);
        // nothing is sent while the part is reloading or erasing
        while (!ready_in)
            @(negedge clk_in);
        // unlocking is only ever done through the whole erase kind
        req_out = '{kind[3], kind[2], kind[1], kind[0], idx, addr, data};
        @(negedge clk_in);
        req_out = '0;
    endtask
endmodule

/* bench/test_option_byte_decoder.sv */
module test_option_byte_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    import option_bytes_pkg::*;
    logic clk, rstn, por, any_rst, sw_rst, sw_wr, dbg_mode, dbg_halt, hard_fault;
    logic vdd_low, idle, ctrl_wr, ready, boot_app, hf_rst, hf_flag, pin_rst, rvalid;
    logic tool_wr, erase_all, wr_ok, bod_rst, wdt_run;
    logic [5:0] pwm_sel, pwm_tri;
    logic [1:0] ctrl_data, ctrl;
    logic [7:0] fdata, rdata;
    logic [7:0] b [4];
    logic [12:0] a;
    logic [31:0] seed = 32'h0000_0026;
    prog_req_t req;
    options_t opts, e;
    int miscompares, check_count, cycles;
    option_byte_decoder option_byte_decoder_inst (.CLK_IN(clk), .RSTN_IN(rstn), .POR_IN(por),
        .ANY_RESET_IN(any_rst), .SW_RESET_IN(sw_rst), .PROG_REQ_IN(req), .FLASH_RDATA_IN(fdata),
        .SW_FLASH_WR_IN(sw_wr), .DEBUG_MODE_IN(dbg_mode), .DEBUG_HALT_IN(dbg_halt),
        .PWM_PIN_SELECT_IN(pwm_sel), .HARD_FAULT_IN(hard_fault), .VDD_LOW_IN(vdd_low),
        .IDLE_IN(idle), .SW_CTRL_WR_IN(ctrl_wr), .SW_CTRL_DATA_IN(ctrl_data),
        .OPTIONS_OUT(opts), .READY_OUT(ready), .BOOT_FROM_APP_OUT(boot_app),
        .PWM_TRISTATE_OUT(pwm_tri), .HARD_FAULT_RESET_OUT(hf_rst), .HARD_FAULT_FLAG_OUT(hf_flag),
        .PIN_RESET_ENABLE_OUT(pin_rst), .PROG_RDATA_OUT(rdata), .PROG_RVALID_OUT(rvalid),
        .FLASH_TOOL_WR_OUT(tool_wr), .FLASH_ERASE_ALL_OUT(erase_all), .SW_FLASH_WR_OK_OUT(wr_ok),
        .BROWNOUT_RESET_OUT(bod_rst), .WDT_RUNNING_OUT(wdt_run), .SW_CTRL_OUT(ctrl));
    option_tool_model tool_inst (.clk_in(clk), .ready_in(ready), .req_out(req),
        .flash_rdata_out(fdata));
    // xorshift, fixed start so every run is the same
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // decoded view expected from the four option bytes
    function automatic options_t dec(input logic [7:0] b0, b1, b2, b3);
        options_t o;
        o = '0;
        o.boot_from_app = b0[7];
        o.pwm_tri_on_halt = b0[5];
        o.debugger_on = !b0[4];
        o.reset_pin_is_reset = b0[2];
        o.chip_locked = !b0[1];
        o.loader_kb = b1[2] ? 5'h07 - 5'(b1[2:0]) : 5'h04;
        o.app_kb = (o.loader_kb == 5'h00) ? 5'h10 : 5'h08 - o.loader_kb;
        o.bod_on = b2[7];
        o.bod_level = b2[5:4];
        o.bod_inhibit = b2[3];
        o.bod_reset_on = b2[2];
        o.wdt_reset_on = b3[7:4] != 4'hF;
        o.wdt_stop_idle = b3[7:4] == 4'h5;
        return o;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // bounded wait for reload or erase to finish
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 64)
        begin
            @(negedge clk);
            n++;
        end
        check("ready", ready, 1'b1);
    endtask
    // one reset event; cause levels held until the reload is over
    task automatic reload(input logic p, s);
        @(negedge clk);
        {por, sw_rst, any_rst} = {p, s, 1'b1};
        @(negedge clk);
        any_rst = 1'b0;
        wait_ready();
        {por, sw_rst} = 2'b00;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // hang guard, far above the several hundred cycles the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            print_verdict();
        end
    end
    initial
    begin
        {rstn, por, any_rst, sw_rst, sw_wr, dbg_mode, dbg_halt, hard_fault} = '0;
        {vdd_low, idle, ctrl_wr, pwm_sel, ctrl_data} = '0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        wait_ready();
        check("blank", opts, dec(8'hFF, 8'hFF, 8'hFF, 8'hFF));
        for (int i = 0; i < 16; i++)
        begin
            foreach (b[k])
                b[k] = rnd();
            // corner watchdog codes first, then random ones
            b[3] = (i == 0) ? 8'h50 : (i == 1) ? 8'hF0 : b[3];
            tool_inst.issue(4'h2, 2'h0, 13'h0000, 8'h00);
            wait_ready();
            check("erased", opts, dec(8'hFF, 8'hFF, 8'hFF, 8'hFF));
            for (int k = 0; k < 4; k++)
                tool_inst.issue(4'h5, 2'(k), 13'h0000, b[k]);
            reload(1'b1, 1'b0);
            e = dec(b[0], b[1], b[2], b[3]);
            check("options", opts, e);
            check("boot", boot_app, b[0][7]);
            check("reset pin", pin_rst, b[0][2]);
            check("ctrl copy", ctrl, {e.wdt_reset_on, e.bod_on});
            a = 13'({rnd(), rnd()});
            tool_inst.issue(4'h8, 2'h0, a, 8'h00);
            check("flash read", rdata, e.chip_locked ? 8'hFF : a[7:0] ^ 8'h5A);
            check("read valid", rvalid, 1'b1);
            tool_inst.issue(4'h9, 2'h0, 13'h0000, 8'h00);
            check("option read", rdata, b[0]);
            tool_inst.issue(4'h4, 2'h0, a, 8'h00);
            repeat (6)
            begin
                @(negedge clk);
                {dbg_halt, vdd_low, idle} = 3'(rnd());
                pwm_sel = 6'(rnd());
                sw_wr = 1'b1;
                #1;
                check("pwm", pwm_tri, (dbg_halt && e.pwm_tri_on_halt)
                    ? pwm_sel : 6'h00);
                check("sw write ok", wr_ok, !(vdd_low && e.bod_on && e.bod_inhibit));
                check("bod reset", bod_rst, vdd_low && e.bod_on && e.bod_reset_on);
                check("wdt run", wdt_run,
                    e.wdt_reset_on && !(idle && e.wdt_stop_idle));
            end
            @(negedge clk);
            {dbg_mode, hard_fault, sw_wr} = 3'b110;
            #1;
            check("fault reset", hf_rst, !e.debugger_on);
            @(negedge clk);
            {dbg_mode, hard_fault} = 2'b00;
            check("fault flag", hf_flag, e.debugger_on);
            ctrl_data = 2'(rnd());
            ctrl_wr = 1'b1;
            @(negedge clk);
            ctrl_wr = 1'b0;
            check("ctrl write", ctrl, ctrl_data);
            // clear boot and brownout bytes; a software reset without power-on follows
            tool_inst.issue(4'h5, 2'h0, 13'h0000, 8'h00);
            tool_inst.issue(4'h5, 2'h2, 13'h0000, 8'h00);
            reload(1'b0, 1'b1);
            check("relock", opts,
                dec(e.chip_locked ? b[0] : 8'h00, b[1], b[2], b[3]));
            check("sw boot", boot_app, b[0][7]);
        end
        // mid-run power loss: the store model comes back blank
        @(negedge clk);
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        wait_ready();
        check("reblank", opts, dec(8'hFF, 8'hFF, 8'hFF, 8'hFF));
        check("reset boot", boot_app, 1'b1);
        print_verdict();
    end
endmodule
